// ==== hw/prescaler_defines.svh ====
`ifndef PRESCALER_DEFINES_SVH
`define PRESCALER_DEFINES_SVH

// ==========================================================================
// division ratios, as terminal counts (ratio - 1)
`define RATIO_LOW_SMALL_TC  8'h3f
`define RATIO_LOW_LARGE_TC  8'h40
`define RATIO_HIGH_SMALL_TC 8'h7f
`define RATIO_HIGH_LARGE_TC 8'h80

// ==========================================================================
// reset values
`define COUNT_RESET         8'h00
`define DIV_OUT_RESET       1'b0
`define SYNC_RESET          3'h0

`endif

// ==== hw/prescaler_pkg.sv ====
package prescaler_pkg;

    // ======================================================================
    // build variant: which downstream edge marks a division cycle
    typedef enum logic
    {
        edge_rising,
        edge_falling
    } edge_variant_t;

    // ======================================================================
    // divider state
    typedef struct packed
    {
        logic [7:0] count;      // position inside current cycle
        logic [7:0] term;       // terminal count latched at cycle start
        logic       div_out;    // divided output level
        logic       range_lat;  // range level used for current cycle
    } div_state_t;

    // ======================================================================
    // synchroniser state: three stages of one level
    typedef struct packed
    {
        logic [2:0] stage;      // stage[0] first, stage[2] last
        logic       level;      // accepted level
    } sync_state_t;

endpackage

// ==== hw/level_sync.sv ====
`include "prescaler_defines.svh"

// ==========================================================================
// three flip-flop synchroniser; change taken when stages two and three agree
module level_sync
    import prescaler_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);

    sync_state_t state;       // registered state
    sync_state_t next_state;  // next value

    // shift chain and agreement check
    always_comb
    begin
        next_state = state;
        next_state.stage = {state.stage[1:0], async_in};
        // first stage is read only by the second stage
        if (state.stage[1] == state.stage[2])
        begin
            next_state.level = state.stage[2];
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '{stage: `SYNC_RESET, level: 1'b0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign sync_out = state.level;

endmodule

// ==== hw/two_modulus_prescaler.sv ====
`include "prescaler_defines.svh"

// Contract
// - range select high 64/65, low 128/129
// - modulus select high small, low large
// - rising variant: one rising edge per cycle
// - falling variant: one falling edge per cycle
module two_modulus_prescaler
    import prescaler_pkg::*;
#(
    parameter edge_variant_t VARIANT = edge_rising
)
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // control pins
    input  wire logic ratio_range_select,
    input  wire logic modulus_select,
    // divided output
    output logic      div_out
);

    // ======================================================================
    // reset release
    logic [1:0] rst_pipe;     // release synchroniser
    logic       rst_n;        // internal reset

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    // ======================================================================
    // pin synchronisers
    logic range_s;            // synchronised range select
    logic mod_s;              // synchronised modulus select

    level_sync u_range_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (ratio_range_select),
        .sync_out (range_s)
    );

    level_sync u_mod_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (modulus_select),
        .sync_out (mod_s)
    );

    // ======================================================================
    // terminal count selection
    logic [7:0] sel_term;     // terminal count for a new cycle

    // pick ratio from range and modulus levels
    always_comb
    begin
        unique case ({range_s, mod_s})
            2'b11:   sel_term = `RATIO_LOW_SMALL_TC;
            2'b10:   sel_term = `RATIO_LOW_LARGE_TC;
            2'b01:   sel_term = `RATIO_HIGH_SMALL_TC;
            2'b00:   sel_term = `RATIO_HIGH_LARGE_TC;
        endcase
    end

    // ======================================================================
    // divider
    div_state_t state;        // registered state
    div_state_t next_state;   // next value
    logic       cycle_end;    // last input cycle of a division cycle
    logic       half_point;   // output change inside the cycle

    assign cycle_end  = (state.count == state.term);
    assign half_point = (state.count == {1'b0, state.term[7:1]});

    // count, reload and output shaping
    always_comb
    begin
        next_state = state;
        if (cycle_end)
        begin
            // new cycle: sample ratio only here
            next_state.count     = `COUNT_RESET;
            next_state.term      = sel_term;
            next_state.range_lat = range_s;
        end
        else
        begin
            next_state.count = state.count + 8'h01;
        end
        // one active edge per division cycle, at cycle start
        if (VARIANT == edge_rising)
        begin
            // rises at start, falls at half point
            if (cycle_end)
            begin
                next_state.div_out = 1'b1;
            end
            else if (half_point)
            begin
                next_state.div_out = 1'b0;
            end
        end
        else
        begin
            // falls at start, rises at half point
            if (cycle_end)
            begin
                next_state.div_out = 1'b0;
            end
            else if (half_point)
            begin
                next_state.div_out = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '{count: `COUNT_RESET, term: `RATIO_HIGH_LARGE_TC,
                       div_out: `DIV_OUT_RESET, range_lat: 1'b0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign div_out = state.div_out;

    // ======================================================================
    // checks
    logic [7:0] gap;          // cycles since last active edge
    logic       act_edge;     // active edge on output
    logic       prev_out;     // output one cycle ago

    // edge spacing counter
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_out <= `DIV_OUT_RESET;
            gap      <= `COUNT_RESET;
        end
        else
        begin
            prev_out <= state.div_out;
            gap      <= act_edge ? 8'h01 : gap + 8'h01;
        end
    end

    assign act_edge = (VARIANT == edge_rising) ? (state.div_out && !prev_out)
                                               : (!state.div_out && prev_out);

    sequence cycle_start_s;
        cycle_end;
    endsequence

    // range high gives the short pair, low the long pair
    ratio_range_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cycle_start_s |=>
        ((state.term <= `RATIO_LOW_LARGE_TC) == state.range_lat))
        else $error("range select picked wrong pair");

    // modulus high gives the smaller ratio of the pair
    ratio_pick_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cycle_start_s |=>
        ((state.term == `RATIO_LOW_SMALL_TC ||
          state.term == `RATIO_HIGH_SMALL_TC) == $past(mod_s)))
        else $error("modulus select picked wrong ratio");

    // ratio frozen for the whole cycle
    term_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !cycle_end |=> $stable(state.term))
        else $error("ratio changed inside a cycle");

    // active edge right after every cycle end
    edge_start_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cycle_start_s |=> act_edge)
        else $error("no active edge at cycle start");

    // edge spacing equals the ratio of the cycle just ended
    edge_space_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        act_edge |-> (gap == $past(state.term) + 8'h01))
        else $error("active edge spacing off ratio");

    // count never passes the latched terminal
    count_bound_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        state.count <= state.term)
        else $error("count ran past terminal");

endmodule

// ==== verification/synth_counter_model.sv ====
// ========================================
// synthesizer counters: set pins after each cycle start
module synth_counter_model
(
    // clock
    input  wire logic core_clk,
    // divided output and wanted levels
    input  wire logic div_out,
    input  wire logic range_want,
    input  wire logic mod_want,
    // pins into the divider
    output logic      ratio_range_select,
    output logic      modulus_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev;  // last divided level
    // known levels from time zero
    initial
    begin
        prev = 1'b0;
        ratio_range_select = 1'b1;
        modulus_select = 1'b1;
    end
    // range settles a cycle ahead of any modulus change
    always @(posedge core_clk)
    begin
        prev <= div_out;
        if (div_out && !prev)
        begin
            if (ratio_range_select != range_want)
                ratio_range_select <= range_want;
            else
                modulus_select <= mod_want;
        end
    end
endmodule

// ==== verification/tb.sv ====
// ========================================
// bench: both variants fed by one counter model
module tb;
    import prescaler_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, arst_n, rw, mw, rsel, msel, div_r, div_f;
    int   fails, checked, cyc;
    // clock and cycle count
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    synth_counter_model u_synth_counter_model
    (
        .core_clk(core_clk), .div_out(div_r), .range_want(rw),
        .mod_want(mw), .ratio_range_select(rsel), .modulus_select(msel)
    );
    two_modulus_prescaler #(.VARIANT(edge_rising)) u_two_modulus_prescaler
    (
        .core_clk(core_clk), .arst_n(arst_n), .ratio_range_select(rsel),
        .modulus_select(msel), .div_out(div_r)
    );
    two_modulus_prescaler #(.VARIANT(edge_falling)) u_two_modulus_prescaler_f
    (
        .core_clk(core_clk), .arst_n(arst_n), .ratio_range_select(rsel),
        .modulus_select(msel), .div_out(div_f)
    );
    // compare two counts
    task automatic chk(input int got, input int exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // cycle number of next active edge of one variant
    task automatic edge_at(input bit fall, output int t);
        int   i;
        logic p, o;
        bit   hit;
        hit = 1'b0;
        for (i = 0; i < 300; i++)
        begin
            p = fall ? ~div_f : div_r;
            @(posedge core_clk);
            #1;
            o = fall ? ~div_f : div_r;
            if (o === 1'b1 && p === 1'b0)
            begin
                hit = 1'b1;
                break;
            end
        end
        // no edge within the limit counts as a mismatch
        if (!hit)
            fails++;
        t = cyc;
    endtask
    // one ratio, both variants
    task automatic ratio_case(input logic r, input logic m, input int n);
        int t0, t1, k;
        rw <= r;
        mw <= m;
        for (k = 0; k < 4; k++)
            edge_at(1'b0, t0);
        edge_at(1'b0, t1);
        chk(t1 - t0, n);
        edge_at(1'b1, t0);
        edge_at(1'b1, t1);
        chk(t1 - t0, n);
    endtask
    // modulus change must not cut the running cycle
    task automatic no_truncate;
        int t0, t1, t2;
        edge_at(1'b0, t0);
        // change lands early in the cycle starting at t0
        mw <= 1'b1;
        edge_at(1'b0, t1);
        edge_at(1'b0, t2);
        chk(t1 - t0, 129);
        chk(t2 - t1, 128);
    endtask
    // verdict and end of run
    task automatic close_out;
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #200000;
        fails++;
        close_out();
    end
    // main sequence
    initial
    begin
        fails = 0;
        checked = 0;
        cyc = 0;
        arst_n = 1'b0;
        rw = 1'b1;
        mw = 1'b1;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        ratio_case(1'b1, 1'b1, 64);
        ratio_case(1'b1, 1'b0, 65);
        ratio_case(1'b0, 1'b1, 128);
        ratio_case(1'b0, 1'b0, 129);
        no_truncate();
        close_out();
    end
endmodule
